// *** verilog/lbw_pkg.sv ***
// Constants shared by the low-battery and watchdog register bank.
// Assumes a 40 MHz core clock; all offsets are byte register addresses.
package lbw_pkg;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] LBW_ADDR_CFG = 8'h0d;
   localparam logic [7:0] LBW_ADDR_TMR = 8'h0e;
   localparam logic [7:0] LBW_ADDR_KICK = 8'h16;
   localparam logic [7:0] LBW_ADDR_STAT = 8'h18;

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int LBW_CFG_EN_BIT = 7;
   localparam int LBW_CFG_TH_MSB = 6;
   localparam int LBW_CFG_TH_LSB = 2;
   localparam int LBW_CFG_HYS_MSB = 1;
   localparam int LBW_TMR_SEL_MSB = 1;
   localparam int LBW_KICK_BIT = 0;
   localparam int LBW_STAT_EVT_BIT = 7;
   localparam logic [7:0] LBW_CFG_RESET = 8'h00;
   localparam logic [1:0] LBW_TMR_RESET = 2'h0;

   // -----------------------------------------------------------------
   // Field encodings
   // -----------------------------------------------------------------
   localparam logic [4:0] LBW_TH_TOP = 5'h1f;
   localparam logic [4:0] LBW_TH_CAP = 5'h1e;
   localparam logic [1:0] LBW_HYS_NONE = 2'h3;
   localparam logic [1:0] LBW_TMR_SEL_SHORT = 2'h0;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int LBW_CLK_PERIOD_NS = 25;
   localparam int LBW_RESTORE_SHORT_NS = 250000;
   localparam int LBW_RESTORE_LONG_NS = 500000;
   localparam int LBW_RESTORE_SHORT_CYC =
      (LBW_RESTORE_SHORT_NS + LBW_CLK_PERIOD_NS - 1) / LBW_CLK_PERIOD_NS;
   localparam int LBW_RESTORE_LONG_CYC =
      (LBW_RESTORE_LONG_NS + LBW_CLK_PERIOD_NS - 1) / LBW_CLK_PERIOD_NS;

   // Gray-coded steps normal -> reduced -> restoring; restoring -> normal flips both bits.
   typedef enum logic [1:0] {
      LBW_NORMAL = 2'b00,
      LBW_REDUCED = 2'b01,
      LBW_RESTORE = 2'b11
   } lbw_state_e;
endpackage

// *** verilog/lbw_restore_timer.sv ***
// Qualification timer for restoring flash current after a low battery.
// Assumes run_i is held high for as long as the battery stays good.
`timescale 1ns/10ps
`default_nettype none
module lbw_restore_timer #(
   parameter int SHORT_CYC = 10000,
   parameter int LONG_CYC = 20000,
   parameter int CNT_W = 15
) (
   input wire logic clk_i, // Core clock.
   input wire logic rst_n_i, // Asynchronous reset, active low.
   input wire logic run_i, // Count while high, clear when low.
   input wire logic long_i, // Select the longer interval.
   output logic done_o // High once the interval has elapsed.
);
   localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(SHORT_CYC - 1);
   localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(LONG_CYC - 1);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] last;

   assign last = long_i ? LONG_LAST : SHORT_LAST;

   // Count qualified cycles; any drop of run_i restarts the interval.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= '0;
         done_o <= 1'b0;
      end else if (!run_i) begin
         cnt_reg <= '0;
         done_o <= 1'b0;
      end else if (cnt_reg >= last) begin
         done_o <= 1'b1; // Sticks until run_i drops.
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** verilog/lbw_regs.sv ***
// Low-battery current-reduction and watchdog kick register bank.
// Assumes a synchronous register port driven by the serial bus engine,
// and comparator levels from the analog side, all on clk_i.
//
// Summary of operation
// - Bit 7 at offset 0x0d enables low-battery current reduction, reset off.
// - A five-bit threshold picks the detect level; codes 30 and 31 are equal.
// - Hysteresis code 0 is 100mV, 1 is 200mV, 3 means never restore.
// - Bits 1:0 at offset 0x0e pick a 0.250ms or 0.500ms restore time.
// - Writing one to bit 0 at offset 0x16 restarts the watchdog.
// - The kick bit clears itself once the watchdog reports the restart.
// - A status bit latches each reduction and clears when it is read.
`timescale 1ns/10ps
`default_nettype none
module lbw_regs
   import lbw_pkg::*;
#(
   parameter int RESTORE_SHORT_CYC = LBW_RESTORE_SHORT_CYC,
   parameter int RESTORE_LONG_CYC = LBW_RESTORE_LONG_CYC
) (
   input wire logic clk_i, // Core clock, 40 MHz.
   input wire logic rst_n_i, // Asynchronous reset, active low.
   input wire logic wr_en_i, // Register write strobe.
   input wire logic rd_en_i, // Register read strobe.
   input wire logic [7:0] addr_i, // Register address.
   input wire logic [7:0] wdata_i, // Write data.
   output logic [7:0] rdata_o, // Read data, valid the cycle after rd_en_i.
   input wire logic batt_below_i, // Battery below selected threshold.
   input wire logic batt_good_i, // Battery above threshold plus hysteresis.
   input wire logic wdt_done_i, // Watchdog reports restart taken.
   output logic wdt_restart_o, // Watchdog restart request, level.
   output logic current_reduce_o, // Flash current reduction active.
   output logic [4:0] threshold_o, // Effective threshold code.
   output logic [1:0] hysteresis_o // Hysteresis code to comparator.
);
   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [7:0] cfg_reg;
   logic [1:0] tmr_sel_reg;
   logic kick_reg;
   logic evt_reg;
   logic reduce_reg;
   lbw_state_e state_reg;
   lbw_state_e state_next;
   logic restore_done;
   logic low_batt_enable;
   logic [4:0] low_batt_threshold;
   logic [1:0] low_batt_hysteresis;
   logic wr_cfg, wr_tmr, wr_kick, rd_stat, trigger;

   assign low_batt_enable = cfg_reg[LBW_CFG_EN_BIT];
   assign low_batt_threshold = cfg_reg[LBW_CFG_TH_MSB:LBW_CFG_TH_LSB];
   assign low_batt_hysteresis = cfg_reg[LBW_CFG_HYS_MSB:0];
   assign wr_cfg = wr_en_i && (addr_i == LBW_ADDR_CFG);
   assign wr_tmr = wr_en_i && (addr_i == LBW_ADDR_TMR);
   assign wr_kick = wr_en_i && (addr_i == LBW_ADDR_KICK)
      && wdata_i[LBW_KICK_BIT];
   assign rd_stat = rd_en_i && (addr_i == LBW_ADDR_STAT);
   assign trigger = (state_reg == LBW_NORMAL) && low_batt_enable
      && batt_below_i;

   // Configuration writes; only the defined timer bits are stored.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_reg <= LBW_CFG_RESET;
         tmr_sel_reg <= LBW_TMR_RESET;
      end else begin
         if (wr_cfg) begin
            cfg_reg <= wdata_i;
         end
         if (wr_tmr) begin
            tmr_sel_reg <= wdata_i[LBW_TMR_SEL_MSB:0];
         end
      end
   end

   // Watchdog kick: the request stands until the watchdog answers, and a
   // fresh kick in the answer cycle keeps it standing so it is not lost.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         kick_reg <= 1'b0;
      end else if (wr_kick) begin
         kick_reg <= 1'b1;
      end else if (wdt_done_i) begin
         kick_reg <= 1'b0;
      end
   end

   assign wdt_restart_o = kick_reg;

   // ----------------------------------------------------------------
   // Current reduction state machine
   // ----------------------------------------------------------------
   lbw_restore_timer #(
      .SHORT_CYC(RESTORE_SHORT_CYC),
      .LONG_CYC(RESTORE_LONG_CYC),
      .CNT_W(16)
   ) u_timer (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i((state_reg == LBW_RESTORE) && batt_good_i),
      .long_i(tmr_sel_reg != LBW_TMR_SEL_SHORT),
      .done_o(restore_done)
   );

   // Next state; with hysteresis off the reduced state is left only when the enable bit clears.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         LBW_NORMAL: begin
            if (trigger) begin
               state_next = LBW_REDUCED;
            end
         end
         LBW_REDUCED: begin
            if (batt_good_i && low_batt_hysteresis != LBW_HYS_NONE) begin
               state_next = LBW_RESTORE;
            end
         end
         LBW_RESTORE: begin
            // A late switch to hysteresis off must still never restore.
            if (!batt_good_i || low_batt_hysteresis == LBW_HYS_NONE) begin
               state_next = LBW_REDUCED;
            end else if (restore_done) begin
               state_next = LBW_NORMAL;
            end
         end
         default: state_next = LBW_NORMAL;
      endcase
      if (!low_batt_enable) begin
         state_next = LBW_NORMAL;
      end
   end

   // State register and comparator settings; codes 30 and 31 share a level.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= LBW_NORMAL;
         reduce_reg <= 1'b0;
         threshold_o <= 5'h00;
         hysteresis_o <= 2'h0;
      end else begin
         state_reg <= state_next;
         reduce_reg <= (state_next != LBW_NORMAL);
         threshold_o <= (low_batt_threshold == LBW_TH_TOP) ?
            LBW_TH_CAP : low_batt_threshold;
         hysteresis_o <= low_batt_hysteresis;
      end
   end

   // Own flop mirrors the state, so the pin never shows decode glitches.
   assign current_reduce_o = reduce_reg;

   // Event flag: a trigger in the read cycle wins over the clear.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_reg <= 1'b0;
      end else if (trigger) begin
         evt_reg <= 1'b1;
      end else if (rd_stat) begin
         evt_reg <= 1'b0;
      end
   end

   // Read data, registered; unmapped addresses and reserved bits read zero.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_en_i) begin
         unique case (addr_i)
            LBW_ADDR_CFG: rdata_o <= cfg_reg;
            LBW_ADDR_TMR: rdata_o <= {6'h00, tmr_sel_reg};
            LBW_ADDR_KICK: rdata_o <= {7'h00, kick_reg};
            LBW_ADDR_STAT: rdata_o <= {evt_reg, 7'h00};
            default: rdata_o <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_enable_store;
      wr_cfg |=> low_batt_enable == $past(wdata_i[LBW_CFG_EN_BIT]);
   endproperty
   a_enable_store: assert property (p_enable_store)
      else $error("enable bit not stored");

   property p_disable_off;
      !low_batt_enable |=> !current_reduce_o;
   endproperty
   a_disable_off: assert property (p_disable_off)
      else $error("reduction active while disabled");

   property p_th_cap;
      wr_cfg && wdata_i[6:2] == LBW_TH_TOP ##1 !wr_cfg
         |=> threshold_o == LBW_TH_CAP;
   endproperty
   a_th_cap: assert property (p_th_cap)
      else $error("top threshold code not capped");

   property p_no_restore;
      current_reduce_o && low_batt_enable
         && low_batt_hysteresis == LBW_HYS_NONE |=> current_reduce_o;
   endproperty
   a_no_restore: assert property (p_no_restore)
      else $error("current restored with hysteresis off");

   property p_tmr_rsvd;
      rd_en_i && addr_i == LBW_ADDR_TMR |=> rdata_o[7:2] == 6'h00;
   endproperty
   a_tmr_rsvd: assert property (p_tmr_rsvd)
      else $error("reserved timer bits read nonzero");

   property p_kick_set;
      wr_kick |=> wdt_restart_o;
   endproperty
   a_kick_set: assert property (p_kick_set)
      else $error("kick did not raise restart request");

   property p_kick_clear;
      wdt_restart_o && wdt_done_i && !wr_kick |=> !wdt_restart_o;
   endproperty
   a_kick_clear: assert property (p_kick_clear)
      else $error("kick bit not cleared on restart");

   property p_kick_hold;
      wdt_restart_o && !wdt_done_i |=> wdt_restart_o;
   endproperty
   a_kick_hold: assert property (p_kick_hold)
      else $error("kick request dropped early");

   property p_reduce;
      trigger |=> current_reduce_o && evt_reg;
   endproperty
   a_reduce: assert property (p_reduce)
      else $error("low battery did not reduce current");

   property p_evt_clear;
      rd_stat && !trigger |=> !evt_reg;
   endproperty
   a_evt_clear: assert property (p_evt_clear)
      else $error("event flag not cleared by read");

   property p_restore_wait;
      $fell(current_reduce_o) && low_batt_enable
         && $past(low_batt_enable) |->
         $past(state_reg) == LBW_RESTORE && $past(restore_done);
   endproperty
   a_restore_wait: assert property (p_restore_wait)
      else $error("current restored before restore time");

   c_reduce: cover property ($rose(current_reduce_o));
   c_restore: cover property ($fell(current_reduce_o) && low_batt_enable);
   c_kick: cover property (wdt_restart_o && wdt_done_i);
   c_evt_read: cover property (rd_stat && evt_reg);
endmodule
`default_nettype wire

// *** testbench/lbw_host_model.sv ***
// Host model: the serial-bus master as seen at the bank's register port.
// Assumes the bank takes strobes at a rising edge of clk_i.
`timescale 1ns/10ps
`default_nettype none
module lbw_host_model
   import lbw_pkg::*;
(
   input wire logic clk_i, // Core clock.
   input wire logic [7:0] rdata_i, // Read data from the bank.
   output logic wr_en_o, // Write strobe.
   output logic rd_en_o, // Read strobe.
   output logic [7:0] addr_o, // Register address.
   output logic [7:0] wdata_o // Write data.
);
   // -----------------------------------------------------------------
   // Register cycles
   // -----------------------------------------------------------------
   // Idle strobes low from time zero.
   initial begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o = 8'hff;
      wdata_o = 8'hff;
   end

   // Codes a careful host never sends are dropped here.
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      if (a == LBW_ADDR_CFG && d[6:2] < 5'h03) return;
      if (a == LBW_ADDR_CFG && d[1:0] == 2'h2) return;
      if (a == LBW_ADDR_TMR && d[1]) return;
      @(posedge clk_i);
      wr_en_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_en_o <= 1'b0;
      addr_o <= ~a; // Released lines must not keep the old value.
      wdata_o <= ~d;
   endtask

   // Read data is taken one edge after the strobe, once it has settled.
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      rd_en_o <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      rd_en_o <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rdata_i;
   endtask
endmodule
`default_nettype wire

// *** testbench/low_battery_and_watchdog_regs_tb_top.sv ***
// Self-checking bench for the low-battery and watchdog register bank.
// Assumes the host model drives the register port; the bench drives the
// comparator levels and the watchdog answer.
`timescale 1ns/10ps
`default_nettype none
module low_battery_and_watchdog_regs_tb_top
   import lbw_pkg::*;
;
   // -----------------------------------------------------------------
   // Clock, reset and instances
   // -----------------------------------------------------------------
   localparam int SHORT_N = 20;
   localparam int LONG_N = 40;
   logic clk_i, rst_n_i, wr_en, rd_en, below, good, wdt_done;
   logic wdt_req, reduce;
   logic [7:0] addr, wdata, rdata, rd;
   logic [4:0] thr;
   logic [1:0] hys;
   int failures = 0;
   int checks_done = 0;

   // Free-running 40 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Short restore counts keep the run brief.
   lbw_regs #(.RESTORE_SHORT_CYC(SHORT_N), .RESTORE_LONG_CYC(LONG_N)) dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
      .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
      .batt_below_i(below), .batt_good_i(good), .wdt_done_i(wdt_done),
      .wdt_restart_o(wdt_req), .current_reduce_o(reduce),
      .threshold_o(thr), .hysteresis_o(hys));
   lbw_host_model host (.clk_i(clk_i), .rdata_i(rdata), .wr_en_o(wr_en),
      .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   // Flags are widened to a byte so one compare serves every result.
   task automatic check(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
      host.read(a, rd);
      check("rdata", exp, rd);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One below-threshold cycle, then the battery reads good again.
   task automatic lb_trip();
      @(posedge clk_i);
      below <= 1'b1;
      @(posedge clk_i);
      below <= 1'b0;
      good <= 1'b1;
      #1;
      check("reduce", 8'h01, {7'h0, reduce});
   endtask

   // Good battery is seen one edge after the trip, the restore state
   // starts on that same edge, done rises n edges later and the state
   // leaves one edge after that, so the current comes back exactly n+2 edges after the trip edge.
   task automatic lb_wait(input int n);
      repeat (n + 1) @(posedge clk_i);
      #1;
      check("reduce", 8'h01, {7'h0, reduce});
      @(posedge clk_i);
      #1;
      check("reduce", 8'h00, {7'h0, reduce});
      good <= 1'b0;
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      rd_check(LBW_ADDR_CFG, LBW_CFG_RESET);
      rd_check(LBW_ADDR_TMR, 8'h00);
      rd_check(LBW_ADDR_KICK, 8'h00);
      rd_check(LBW_ADDR_STAT, 8'h00);
      rd_check(8'h20, 8'h00);
   endtask

   task automatic t_config();
      host.write(LBW_ADDR_CFG, 8'h8d);
      rd_check(LBW_ADDR_CFG, 8'h8d);
      check("threshold", 8'h03, {3'h0, thr});
      check("hysteresis", 8'h01, {6'h0, hys});
      host.write(LBW_ADDR_CFG, 8'h7c);
      rd_check(LBW_ADDR_TMR, 8'h00);
      check("threshold", {3'h0, LBW_TH_CAP}, {3'h0, thr});
      host.write(LBW_ADDR_TMR, 8'hfd);
      rd_check(LBW_ADDR_TMR, 8'h01);
      host.write(LBW_ADDR_STAT, 8'hff);
      rd_check(LBW_ADDR_STAT, 8'h00);
      host.write(LBW_ADDR_TMR, 8'h00);
   endtask

   task automatic t_kick();
      host.write(LBW_ADDR_KICK, 8'hfe);
      #1;
      check("wdt_restart", 8'h00, {7'h0, wdt_req});
      host.write(LBW_ADDR_KICK, 8'h01);
      #1;
      check("wdt_restart", 8'h01, {7'h0, wdt_req});
      rd_check(LBW_ADDR_KICK, 8'h01);
      @(posedge clk_i);
      wdt_done <= 1'b1;
      @(posedge clk_i);
      wdt_done <= 1'b0;
      #1;
      check("wdt_restart", 8'h00, {7'h0, wdt_req});
      rd_check(LBW_ADDR_KICK, 8'h00);
   endtask

   task automatic t_restore_short();
      host.write(LBW_ADDR_CFG, 8'h8c);
      lb_trip();
      lb_wait(SHORT_N);
      rd_check(LBW_ADDR_STAT, 8'h80);
      rd_check(LBW_ADDR_STAT, 8'h00);
   endtask

   task automatic t_restore_long();
      host.write(LBW_ADDR_TMR, 8'h01);
      lb_trip();
      lb_wait(LONG_N);
   endtask

   task automatic t_no_restore();
      host.write(LBW_ADDR_CFG, 8'h8f);
      lb_trip();
      repeat (3 * LONG_N) @(posedge clk_i);
      #1;
      check("reduce", 8'h01, {7'h0, reduce});
      host.write(LBW_ADDR_CFG, 8'h0f);
      @(posedge clk_i);
      #1;
      check("reduce", 8'h00, {7'h0, reduce});
      good <= 1'b0;
   endtask

   // Main sequence: reset for 16 cycles, then every scenario in turn.
   initial begin
      rst_n_i = 1'b0;
      below = 1'b0;
      good = 1'b0;
      wdt_done = 1'b0;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_config();
      t_kick();
      t_restore_short();
      t_restore_long();
      t_no_restore();
      report_and_stop();
   end

   // Watchdog: the scenarios need well under 1000 cycles.
   initial begin
      #(25 * 4000);
      failures++;
      $display("ERROR watchdog expected finish seen hang");
      report_and_stop();
   end
endmodule
`default_nettype wire
